/* logic/dhlcr_pkg.sv */
// constants, field layouts and state codes for the dac load/clear/reset control
package dhlcr_pkg;
   localparam int NUM_CH = 32;
   localparam int DATA_W = 12;
   localparam int ADDR_W = 6;
   localparam int NUM_ADDR = 40;
   localparam int REGSEL_W = 2;
   localparam int CNT_W = 16;
   localparam int SHIFT_W = 24;
   localparam int FIFO_DEPTH = 4;
   localparam int ENT_W = REGSEL_W + ADDR_W + DATA_W;
   // reg_select encodings
   localparam logic [1:0] REG_SFR = 2'h0;
   localparam logic [1:0] REG_GAIN = 2'h1;
   localparam logic [1:0] REG_OFFS = 2'h2;
   localparam logic [1:0] REG_INPUT = 2'h3;
   // special function register address holding the clear code
   localparam logic [5:0] SFR_CLR_CODE = 6'h02;
   // power-on defaults, then offset midpoint and top code for the calculation
   localparam logic [11:0] DEF_INPUT = 12'h000;
   localparam logic [11:0] DEF_OFFS = 12'h800;
   localparam logic [11:0] DEF_GAIN = 12'hfff;
   localparam logic [11:0] DEF_X2 = 12'h000;
   localparam logic [11:0] DEF_CLR_CODE = 12'h000;
   localparam logic [13:0] OFFS_MID = 14'h0800;
   localparam logic [13:0] CODE_MAX = 14'h0fff;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int CLR_TIME_NS = 35000;
   localparam int RST_TIME_NS = 270000;
   localparam int CLR_CYCLES = (CLR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CALC_CYCLES = 16;
   // fourteen control pins plus the whole bus word
   localparam int SYNC_W = 14 + ENT_W;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CALC = 2'h1,
      ST_CLEAR = 2'h3,
      ST_RESET = 2'h2
   } dhlcr_state_type;
endpackage

/* logic/dhlcr_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps
module dhlcr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,               // system clock
   input wire logic sys_rst,             // synchronous reset, active high
   input wire logic [WIDTH-1:0] async_in, // pins from outside the domain
   output logic [WIDTH-1:0] sync_out     // synchronised copy
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_out <= nxt_sync;
      end
   end
endmodule // dhlcr_sync

/* logic/dhlcr_ctrl.sv */
// parallel write, load, clear and reset control of a 32-channel 12-bit dac
// Contract
// - write data on strobe rising edge, select low
// - spi daisy chain when serial and chain_enable
// - i2c address from both strap pins
// - 12-bit data word, line 11 is msb
// - address decodes one of 40 channel addresses; only addresses 0 to 31 are decoded as channels here
// - reg_select picks input, offset, gain or special
// - serial_out shifts on sclk rise, tri-stateable
// - two data registers per channel, ab_select picks
// - toggle mode load swaps outputs between a and b
// - busy low while computing, writes queued in fifo
// - load while busy high updates all outputs
// - load while calculating is stored, done later
// - load ignored and interface off during reset; here only parallel writes stop, spi shifting and serial_out go on
// - busy low through power-on reset
// - clear edge loads clear code, busy low 35us
// - reset edge restores defaults, busy low 270us
// - reset input ignored until next falling edge
// - chip_select_n level sensitive, active low
// - interface_select high serial, low parallel
// - serial_protocol_select low spi, high i2c
`timescale 1ns/100ps
module dhlcr_ctrl
   import dhlcr_pkg::*;
#(
   parameter int CLR_CYCLES_P = CLR_CYCLES,
   parameter int RST_CYCLES_P = RST_CYCLES,
   parameter int CALC_CYCLES_P = CALC_CYCLES,
   parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
   input wire logic clock,                  // 125 mhz system clock
   input wire logic sys_rst,                // power-on reset, sync, high
   input wire logic write_strobe_n,         // parallel write strobe
   input wire logic chip_select_n,          // chip select / serial frame
   input wire logic [DATA_W-1:0] par_data_bus, // parallel data word
   input wire logic [ADDR_W-1:0] chan_addr_bus, // channel address
   input wire logic [1:0] reg_select,       // destination register kind
   input wire logic ab_select,              // toggle mode a/b target
   input wire logic load_outputs_n,         // load dac outputs
   input wire logic clear_n,                // clear to clear code
   input wire logic reset_n,                // digital reset pin
   input wire logic interface_select,       // high serial, low parallel
   input wire logic serial_protocol_select, // low spi, high i2c
   input wire logic chain_enable,           // spi daisy chain enable
   input wire logic i2c_addr_pin0,          // i2c address strap 0
   input wire logic i2c_addr_pin1,          // i2c address strap 1
   input wire logic toggle_mode,            // toggle mode enable
   input wire logic serial_clk,             // spi serial clock
   input wire logic serial_in,              // spi serial data in
   output logic busy,                       // high when idle
   output logic [NUM_CH*DATA_W-1:0] dac_code, // output codes, ch0 low
   output logic ab_state,                   // bank shown in toggle mode
   output logic fifo_full,                  // write queue full
   output logic parallel_mode,              // parallel port active
   output logic daisy_chain_mode,           // spi daisy chain active
   output logic i2c_mode,                   // i2c selected
   output logic [1:0] i2c_addr,             // strap address bits
   output logic serial_out,                 // serial data out
   output logic serial_out_oe_n             // low while serial_out drives
);
   localparam int PTR_W = $clog2(FIFO_DEPTH_P);

   function automatic logic ch_valid(input logic [ADDR_W-1:0] a);
      ch_valid = a < ADDR_W'(NUM_CH);
   endfunction

   function automatic logic [DATA_W-1:0] calc_x2(input logic [11:0] x1,
      input logic [11:0] m, input logic [11:0] c);
      logic [25:0] prod;
      logic [13:0] sum;
      prod = 26'(x1 * (13'(m) + 13'h1));
      sum = 14'(prod[23:12]) + 14'(c);
      if (sum < OFFS_MID) calc_x2 = 12'h000;
      else if (sum - OFFS_MID > CODE_MAX) calc_x2 = 12'hfff;
      else calc_x2 = 12'(sum - OFFS_MID);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [SYNC_W-1:0] sync_w;
   logic s_wr_n, s_cs_n, s_ab, s_load_n, s_clr_n, s_rst_n, s_if, s_proto;
   logic s_chain, s_ad0, s_ad1, s_tog, s_sclk, s_sdin;
   logic [DATA_W-1:0] s_data;
   logic [ADDR_W-1:0] s_addr;
   logic [1:0] s_reg;

   // every pin passes two flops, so each edge is seen once
   dhlcr_sync #(.WIDTH(SYNC_W)) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({write_strobe_n, chip_select_n, ab_select, load_outputs_n,
         clear_n, reset_n, interface_select, serial_protocol_select,
         chain_enable, i2c_addr_pin0, i2c_addr_pin1, toggle_mode, serial_clk,
         serial_in, par_data_bus, chan_addr_bus, reg_select}),
      .sync_out(sync_w)
   );
   // bus lines share the strobe's two flops, so they arrive aligned with it
   assign {s_wr_n, s_cs_n, s_ab, s_load_n, s_clr_n, s_rst_n, s_if, s_proto,
      s_chain, s_ad0, s_ad1, s_tog, s_sclk, s_sdin, s_data, s_addr,
      s_reg} = sync_w;

   ////////////////////////////////////////////////////////////////////////
   // edges and modes
   logic [4:0] prev_ff, nxt_prev;
   logic [4:0] mode_ff, nxt_mode;
   logic wr_rise, load_fall, clr_fall, rst_fall, sclk_rise, sclk_fall;
   logic spi_sel;

   always_comb begin
      nxt_prev = {s_wr_n, s_load_n, s_clr_n, s_rst_n, s_sclk};
      nxt_mode[0] = ~s_if;
      nxt_mode[1] = s_if & ~s_proto & s_chain;
      nxt_mode[2] = s_if & s_proto;
      nxt_mode[4:3] = {s_ad1, s_ad0};
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         // track the synchroniser so its reset level fakes no edge
         prev_ff <= nxt_prev;
         mode_ff <= 5'h00;
      end else begin
         prev_ff <= nxt_prev;
         mode_ff <= nxt_mode;
      end
   end

   // strobe edge only counts while the select level is low
   assign wr_rise = s_wr_n & ~prev_ff[4] & ~s_cs_n & mode_ff[0];
   assign load_fall = ~s_load_n & prev_ff[3];
   assign clr_fall = ~s_clr_n & prev_ff[2];
   // edge, not level: a held low reset pin does nothing more
   assign rst_fall = ~s_rst_n & prev_ff[1];
   assign sclk_rise = s_sclk & ~prev_ff[0];
   assign sclk_fall = ~s_sclk & prev_ff[0];
   assign spi_sel = s_if & ~s_proto;
   assign parallel_mode = mode_ff[0];
   assign daisy_chain_mode = mode_ff[1];
   assign i2c_mode = mode_ff[2];
   assign i2c_addr = mode_ff[4:3];

   ////////////////////////////////////////////////////////////////////////
   // serial out: data in on sclk fall, next bit out on sclk rise
   logic [SHIFT_W-1:0] sh_ff, nxt_sh;
   logic sdo_ff, nxt_sdo, oe_n_ff, nxt_oe_n;

   always_comb begin
      nxt_sh = sh_ff;
      nxt_sdo = sdo_ff;
      nxt_oe_n = ~(spi_sel & ~s_cs_n);
      if (spi_sel && !s_cs_n && sclk_fall) nxt_sh = {sh_ff[SHIFT_W-2:0], s_sdin};
      if (spi_sel && !s_cs_n && sclk_rise) nxt_sdo = sh_ff[SHIFT_W-1];
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sh_ff <= '0;
         sdo_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end else begin
         sh_ff <= nxt_sh;
         sdo_ff <= nxt_sdo;
         oe_n_ff <= nxt_oe_n;
      end
   end
   assign serial_out = sdo_ff;
   assign serial_out_oe_n = oe_n_ff;

   ////////////////////////////////////////////////////////////////////////
   // write queue, state machine and register arrays
   logic [ENT_W:0] fifo_ff [FIFO_DEPTH_P];
   logic [ENT_W:0] nxt_fifo [FIFO_DEPTH_P];
   logic [PTR_W-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [PTR_W:0] cnt_q_ff, nxt_cnt_q;
   dhlcr_state_type state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic load_pend_ff, nxt_load_pend, ab_ff, nxt_ab;
   logic [4:0] calc_ch_ff, nxt_calc_ch;
   logic [DATA_W-1:0] clr_code_ff, nxt_clr_code;
   logic [DATA_W-1:0] in_a_ff [NUM_CH], in_b_ff [NUM_CH], offs_ff [NUM_CH];
   logic [DATA_W-1:0] gain_ff [NUM_CH], x2a_ff [NUM_CH], x2b_ff [NUM_CH];
   logic [DATA_W-1:0] out_ff [NUM_CH];
   logic [DATA_W-1:0] nxt_in_a [NUM_CH], nxt_in_b [NUM_CH];
   logic [DATA_W-1:0] nxt_offs [NUM_CH], nxt_gain [NUM_CH];
   logic [DATA_W-1:0] nxt_x2a [NUM_CH], nxt_x2b [NUM_CH], nxt_out [NUM_CH];
   logic push, pop, do_load;
   logic [ENT_W:0] ent;

   assign fifo_full = cnt_q_ff == (PTR_W+1)'(FIFO_DEPTH_P);
   // writes are refused outright while the reset sequence runs
   assign push = wr_rise & (state_ff != ST_RESET) & ~fifo_full;
   assign do_load = (state_ff == ST_IDLE) & (load_fall | load_pend_ff)
      & ~clr_fall & ~rst_fall;
   assign pop = (state_ff == ST_IDLE) & ~do_load & ~clr_fall & ~rst_fall
      & (cnt_q_ff != '0);
   assign ent = fifo_ff[rp_ff];
   assign busy = state_ff == ST_IDLE;

   always_comb begin
      nxt_fifo = fifo_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_cnt_q = cnt_q_ff;
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 16'h0001;
      nxt_load_pend = load_pend_ff;
      nxt_ab = ab_ff;
      nxt_calc_ch = calc_ch_ff;
      nxt_clr_code = clr_code_ff;
      nxt_in_a = in_a_ff;
      nxt_in_b = in_b_ff;
      nxt_offs = offs_ff;
      nxt_gain = gain_ff;
      nxt_x2a = x2a_ff;
      nxt_x2b = x2b_ff;
      nxt_out = out_ff;
      // writes land in the queue in the idle, calculation and clear states, not during reset
      if (push) begin
         nxt_fifo[wp_ff] = {s_tog & s_ab, s_reg, s_addr, s_data};
         nxt_wp = wp_ff + 1'b1;
      end
      nxt_cnt_q = cnt_q_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      if (pop) nxt_rp = rp_ff + 1'b1;
      unique case (state_ff)
         ST_IDLE: begin
            if (do_load) begin
               nxt_load_pend = 1'b0;
               nxt_ab = s_tog ? ~ab_ff : 1'b0;
               for (int i = 0; i < NUM_CH; i++) begin
                  nxt_out[i] = (s_tog && !ab_ff) ? x2b_ff[i] : x2a_ff[i];
               end
            end else if (pop) begin
               if (ent[19:18] == REG_SFR) begin
                  if (ent[17:12] == SFR_CLR_CODE) nxt_clr_code = ent[11:0];
               end else if (ch_valid(ent[17:12])) begin
                  unique case (ent[19:18])
                     REG_INPUT: begin
                        if (ent[20]) nxt_in_b[ent[16:12]] = ent[11:0];
                        else nxt_in_a[ent[16:12]] = ent[11:0];
                     end
                     REG_OFFS: nxt_offs[ent[16:12]] = ent[11:0];
                     default: nxt_gain[ent[16:12]] = ent[11:0];
                  endcase
                  nxt_calc_ch = ent[16:12];
                  nxt_state = ST_CALC;
                  nxt_cnt = '0;
               end
            end
         end
         ST_CALC: begin
            // dac registers only change once the calculation ends
            if (cnt_ff >= CNT_W'(CALC_CYCLES_P - 1)) begin
               nxt_x2a[calc_ch_ff] = calc_x2(in_a_ff[calc_ch_ff],
                  gain_ff[calc_ch_ff], offs_ff[calc_ch_ff]);
               nxt_x2b[calc_ch_ff] = calc_x2(in_b_ff[calc_ch_ff],
                  gain_ff[calc_ch_ff], offs_ff[calc_ch_ff]);
               nxt_state = ST_IDLE;
            end
         end
         ST_CLEAR: begin
            if (cnt_ff >= CNT_W'(CLR_CYCLES_P - 1)) nxt_state = ST_IDLE;
         end
         ST_RESET: begin
            // defaults held all through; queue and load requests dropped
            nxt_load_pend = 1'b0;
            nxt_ab = 1'b0;
            nxt_wp = '0;
            nxt_rp = '0;
            nxt_cnt_q = '0;
            nxt_clr_code = DEF_CLR_CODE;
            for (int i = 0; i < NUM_CH; i++) begin
               nxt_in_a[i] = DEF_INPUT;
               nxt_in_b[i] = DEF_INPUT;
               nxt_offs[i] = DEF_OFFS;
               nxt_gain[i] = DEF_GAIN;
               nxt_x2a[i] = DEF_X2;
               nxt_x2b[i] = DEF_X2;
               nxt_out[i] = DEF_X2;
            end
            if (cnt_ff >= CNT_W'(RST_CYCLES_P - 1)) nxt_state = ST_IDLE;
         end
      endcase
      // a load during a calculation or clear waits for busy to rise
      if (load_fall && state_ff != ST_IDLE && state_ff != ST_RESET) begin
         nxt_load_pend = 1'b1;
      end
      if (clr_fall && state_ff != ST_RESET) begin
         nxt_state = ST_CLEAR;
         nxt_cnt = '0;
         for (int i = 0; i < NUM_CH; i++) begin
            nxt_x2a[i] = clr_code_ff;
            nxt_x2b[i] = clr_code_ff;
            nxt_out[i] = clr_code_ff;
         end
      end
      // a fresh edge inside the sequence is not restarted
      if (rst_fall && state_ff != ST_RESET) begin
         nxt_state = ST_RESET;
         nxt_cnt = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         // power-on runs the same sequence as the reset pin
         state_ff <= ST_RESET;
         cnt_ff <= '0;
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_q_ff <= '0;
         load_pend_ff <= 1'b0;
         ab_ff <= 1'b0;
         calc_ch_ff <= '0;
         clr_code_ff <= DEF_CLR_CODE;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_q_ff <= nxt_cnt_q;
         load_pend_ff <= nxt_load_pend;
         ab_ff <= nxt_ab;
         calc_ch_ff <= nxt_calc_ch;
         clr_code_ff <= nxt_clr_code;
      end
   end

   // data arrays are restored by the reset state and the queue pointers cleared, so none needs a reset of its own
   always_ff @(posedge clock) begin
      fifo_ff <= nxt_fifo;
      in_a_ff <= nxt_in_a;
      in_b_ff <= nxt_in_b;
      offs_ff <= nxt_offs;
      gain_ff <= nxt_gain;
      x2a_ff <= nxt_x2a;
      x2b_ff <= nxt_x2b;
      out_ff <= nxt_out;
   end

   for (genvar g = 0; g < NUM_CH; g++) begin : g_flat
      assign dac_code[g*DATA_W +: DATA_W] = out_ff[g];
   end
   assign ab_state = ab_ff;

   ////////////////////////////////////////////////////////////////////////
   a_por_busy: assert property (@(posedge clock) sys_rst |=> !busy)
      else $error("busy high after power-on reset");
   a_rst_busy: assert property (@(posedge clock) disable iff (sys_rst)
      (rst_fall && state_ff != ST_RESET) |=> !busy [*8])
      else $error("busy rose early in reset sequence");
   a_clr_code: assert property (@(posedge clock) disable iff (sys_rst)
      (clr_fall && state_ff != ST_RESET && !rst_fall)
      |=> out_ff[0] == $past(clr_code_ff) && state_ff == ST_CLEAR)
      else $error("clear code not loaded");
   a_clr_hold: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_CLEAR && cnt_ff < CNT_W'(CLR_CYCLES_P - 1) && !rst_fall)
      |=> state_ff == ST_CLEAR)
      else $error("clear ended early");
   a_load_pend: assert property (@(posedge clock)
      disable iff (sys_rst)
      (load_fall && state_ff == ST_CALC) |=> load_pend_ff)
      else $error("load during calculation lost");
   a_load_rst: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_RESET) |=> !load_pend_ff)
      else $error("load kept during reset");
   a_write_queue: assert property (@(posedge clock)
      disable iff (sys_rst)
      (push && !pop && state_ff != ST_RESET)
      |=> cnt_q_ff == $past(cnt_q_ff) + 1'b1)
      else $error("write not queued");
   a_calc_out: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_CALC && !clr_fall && !rst_fall) |=> out_ff[0] ==
      $past(out_ff[0]))
      else $error("output changed during calculation");
   a_calc_busy: assert property (@(posedge clock)
      disable iff (sys_rst)
      (state_ff == ST_CALC && cnt_ff == CNT_W'(CALC_CYCLES_P - 1)
      && !clr_fall && !rst_fall) |=> busy)
      else $error("busy stayed low after calculation");
   a_load_now: assert property (@(posedge clock) disable iff (sys_rst)
      (do_load && !s_tog) |=> out_ff[1] == $past(x2a_ff[1]))
      else $error("load did not update outputs");
endmodule // dhlcr_ctrl

/* sim/dhlcr_host.sv */
// host processor model driving the parallel bus and the event pins
`timescale 1ns/100ps
module dhlcr_host
   import dhlcr_pkg::*;
(
   input wire logic clock,                 // system clock
   output logic write_strobe_n,            // write strobe
   output logic chip_select_n,             // chip select
   output logic [DATA_W-1:0] par_data_bus, // data word
   output logic [ADDR_W-1:0] chan_addr_bus, // channel address
   output logic [1:0] reg_select,          // register kind
   output logic ab_select,                 // a/b target
   output logic load_outputs_n,            // load request
   output logic clear_n,                   // clear request
   output logic reset_n                    // reset request
);
   initial begin
      write_strobe_n = 1'b1;
      chip_select_n = 1'b1;
      par_data_bus = 12'h5a5;
      chan_addr_bus = 6'h00;
      reg_select = 2'h0;
      ab_select = 1'b0;
      load_outputs_n = 1'b1;
      clear_n = 1'b1;
      reset_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // bus lines pass the same two flops as the strobe, so they are held
   // well past the strobe rise
   task automatic write(input logic [1:0] rs, input logic [5:0] a,
         input logic [11:0] d, input logic ab, input logic cs_n);
      @(posedge clock);
      chip_select_n <= cs_n;
      reg_select <= rs;
      chan_addr_bus <= a;
      par_data_bus <= d;
      ab_select <= ab;
      @(posedge clock);
      write_strobe_n <= 1'b0;
      repeat (3) @(posedge clock);
      write_strobe_n <= 1'b1;
      repeat (4) @(posedge clock);
      chip_select_n <= 1'b1;
      par_data_bus <= ~d; // released bus shows the inverse
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // sel 0 load, 1 clear, 2 reset
   task automatic pulse(input int sel, input int hold = 4);
      @(posedge clock);
      case (sel)
         0: load_outputs_n <= 1'b0;
         1: clear_n <= 1'b0;
         default: reset_n <= 1'b0;
      endcase
      repeat (hold) @(posedge clock);
      case (sel)
         0: load_outputs_n <= 1'b1;
         1: clear_n <= 1'b1;
         default: reset_n <= 1'b1;
      endcase
      repeat (4) @(posedge clock);
      #1;
   endtask
endmodule // dhlcr_host

/* sim/dac_host_load_clear_reset_ctrl_tb.sv */
// self-checking bench for the dac load, clear and reset control
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module dac_host_load_clear_reset_ctrl_tb
   import dhlcr_pkg::*;
();
   localparam int CLR_P = 20;
   localparam int RST_P = 40;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic wr_n, cs_n, ab, ld_n, clr_n, rst_n;
   logic [11:0] db;
   logic [5:0] adr;
   logic [1:0] rs;
   logic if_sel, sps, ce, ap0, ap1, tgl, sclk, sin;
   logic busy, ab_state, fifo_full, par_m, dc_m, i2c_m, sout, sout_oe_n;
   logic [NUM_CH*DATA_W-1:0] dac_code;
   logic [1:0] i2c_addr;
   logic saw_full = 1'b0;
   int mismatches = 0;
   int num_checks = 0;
   always #4 clock = ~clock;
   always @(posedge clock) if (fifo_full === 1'b1) saw_full <= 1'b1;
   dhlcr_host host (.clock(clock), .write_strobe_n(wr_n),
      .chip_select_n(cs_n), .par_data_bus(db), .chan_addr_bus(adr),
      .reg_select(rs), .ab_select(ab), .load_outputs_n(ld_n),
      .clear_n(clr_n), .reset_n(rst_n));
   dhlcr_ctrl #(.CLR_CYCLES_P(CLR_P), .RST_CYCLES_P(RST_P)) dut (
      .clock(clock),
      .sys_rst(sys_rst), .write_strobe_n(wr_n), .chip_select_n(cs_n),
      .par_data_bus(db), .chan_addr_bus(adr), .reg_select(rs),
      .ab_select(ab), .load_outputs_n(ld_n), .clear_n(clr_n),
      .reset_n(rst_n), .interface_select(if_sel),
      .serial_protocol_select(sps), .chain_enable(ce),
      .i2c_addr_pin0(ap0), .i2c_addr_pin1(ap1), .toggle_mode(tgl),
      .serial_clk(sclk), .serial_in(sin), .busy(busy),
      .dac_code(dac_code), .ab_state(ab_state), .fifo_full(fifo_full),
      .parallel_mode(par_m), .daisy_chain_mode(dc_m), .i2c_mode(i2c_m),
      .i2c_addr(i2c_addr), .serial_out(sout),
      .serial_out_oe_n(sout_oe_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // busy may lag a write by a few cycles, so give it time to fall first;
   // a one-cycle idle gap between queued writes is not the end
   task automatic wait_idle(input int lim);
      int i;
      int n;
      n = 0;
      tick(3);
      for (i = 0; i < lim && n < 2; i++) begin
         n = (busy === 1'b1) ? n + 1 : 0;
         tick(1);
      end
      `CHK("idle_wait", 2, n)
   endtask
   task automatic measure_low(input int exp, input string nm);
      int n;
      n = 0;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) tick(1);
      while (busy === 1'b0 && n < 2000) begin
         n++;
         tick(1);
      end
      `CHK(nm, exp, n)
   endtask
   task automatic chk_ch(input int ch, input logic [11:0] e, input string nm);
      `CHK(nm, e, dac_code[ch*DATA_W +: DATA_W])
   endtask
   function automatic logic [11:0] xfer(input int x, input int m, input int c);
      int v;
      v = x * (m + 1) / 4096 + c - 2048;
      if (v < 0) v = 0;
      if (v > 4095) v = 4095;
      return v[11:0];
   endfunction
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clock);
      mismatches++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      int ch, d, m, c, i;
      logic [11:0] td [2];
      logic e;
      d = $urandom(32'h59bf46e3);
      {if_sel, sps, ce, ap1, ap0, tgl, sclk, sin} <= 8'h00;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      `CHK("busy_por", 1'b0, busy)
      wait_idle(200);
      `CHK("busy_idle", 1'b1, busy)
      `CHK("dac_por", {NUM_CH*DATA_W{1'b0}}, dac_code)
      $display("test reset done");
      // the last pass returns to parallel mode
      for (i = 0; i <= 32; i++) begin
         d = $urandom;
         @(posedge clock);
         if_sel <= i[4];
         sps <= i[3];
         ce <= i[2];
         ap1 <= i[1];
         ap0 <= i[0];
         sclk <= d[0];
         sin <= d[1];
         tick(4);
         `CHK("par_mode", ~i[4], par_m)
         `CHK("chain_mode", i[4] & ~i[3] & i[2], dc_m)
         `CHK("i2c_mode", i[4] & i[3], i2c_m)
         `CHK("i2c_addr", i[1:0], i2c_addr)
         `CHK("sout_oe_n", 1'b1, sout_oe_n)
      end
      $display("test modes done");
      for (i = 0; i < 6; i++) begin
         ch = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(31);
         d = (i == 0) ? 4095 : $urandom_range(4095);
         host.write(REG_INPUT, ch[5:0], d[11:0], 1'b0, 1'b0);
         wait_idle(100);
         host.pulse(0);
         chk_ch(ch, d[11:0], "write_load");
      end
      host.write(REG_INPUT, ch[5:0], ~d[11:0], 1'b0, 1'b1);
      wait_idle(100);
      host.pulse(0);
      chk_ch(ch, d[11:0], "cs_high");
      $display("test writes done");
      for (i = 0; i < 2; i++) begin
         ch = $urandom_range(31);
         m = (i == 0) ? 4095 : $urandom_range(4095);
         c = (i == 0) ? 0 : $urandom_range(4095);
         d = (i == 0) ? 100 : $urandom_range(4095);
         host.write(REG_GAIN, ch[5:0], m[11:0], 1'b0, 1'b0);
         wait_idle(100);
         host.write(REG_OFFS, ch[5:0], c[11:0], 1'b0, 1'b0);
         wait_idle(100);
         host.write(REG_INPUT, ch[5:0], d[11:0], 1'b0, 1'b0);
         wait_idle(100);
         host.pulse(0);
         chk_ch(ch, xfer(d, m, c), "gain_offs");
      end
      d = $urandom_range(4095);
      host.write(REG_INPUT, 6'h05, d[11:0], 1'b0, 1'b0);
      tick(1);
      `CHK("busy_calc", 1'b0, busy)
      host.pulse(0);
      wait_idle(100);
      tick(3);
      chk_ch(5, d[11:0], "load_stored");
      $display("test calc done");
      saw_full <= 1'b0;
      for (i = 0; i < 10; i++) begin
         d = 256 + i;
         host.write(REG_INPUT, i[5:0], d[11:0], 1'b0, 1'b0);
      end
      `CHK("saw_full", 1'b1, saw_full)
      wait_idle(400);
      `CHK("fifo_drained", 1'b0, fifo_full)
      host.pulse(0);
      chk_ch(0, 12'h100, "fifo_first");
      $display("test fifo done");
      d = $urandom_range(4095);
      host.write(REG_SFR, SFR_CLR_CODE, d[11:0], 1'b0, 1'b0);
      wait_idle(100);
      fork
         host.pulse(1);
         measure_low(CLR_P, "clear_busy");
      join
      `CHK("clear_all", {NUM_CH{d[11:0]}}, dac_code)
      $display("test clear done");
      fork
         host.pulse(2, 60);
         measure_low(RST_P, "reset_busy");
         begin
            tick(8);
            host.pulse(0);
         end
      join
      `CHK("dac_reset", {NUM_CH*DATA_W{1'b0}}, dac_code)
      tick(10);
      `CHK("busy_after_rst", 1'b1, busy)
      $display("test pin reset done");
      @(posedge clock);
      tgl <= ~tgl;
      td[0] = $urandom_range(4095);
      td[1] = ~td[0];
      host.write(REG_INPUT, 6'h09, td[0], 1'b0, 1'b0);
      wait_idle(100);
      host.write(REG_INPUT, 6'h09, td[1], 1'b1, 1'b0);
      wait_idle(100);
      for (i = 0; i < 3; i++) begin
         e = ~i[0];
         host.pulse(0);
         `CHK("ab_state", e, ab_state)
         chk_ch(9, td[e], "toggle_bank");
      end
      $display("test toggle done");
      end_sim();
   end
endmodule // dac_host_load_clear_reset_ctrl_tb
